// ===== pkg/ssl_pkg.sv
// constants, field layouts and codes of the serial load and control pin block
package ssl_pkg;

	// ****************************************************************
	// serial word and latch bank
	// ****************************************************************
	localparam int SSL_WORD_W = 32;
	localparam int SSL_SEL_W = 3;
	localparam int SSL_SEL_LSB = 0;
	localparam int SSL_LATCH_N = 6;
	localparam logic [2:0] SSL_SEL_LAST = 3'h5;
	localparam logic [2:0] SSL_SEL_ZERO = 3'h0;
	localparam logic [31:0] SSL_WORD_RST = 32'h0000_0000;

	// ****************************************************************
	// fields inside the latches
	// ****************************************************************
	localparam int SSL_L2_MUX_LSB = 26;
	localparam int SSL_L2_PD_BIT = 5;
	localparam int SSL_L2_DIVBUF_BIT = 13;
	localparam int SSL_L4_LEVEL_LSB = 3;
	localparam int SSL_L4_RFEN_BIT = 5;
	localparam int SSL_L4_MTLD_BIT = 10;
	localparam int SSL_L4_DIV_LSB = 20;

	// ****************************************************************
	// test multiplexer sources
	// ****************************************************************
	typedef enum logic [2:0] {
		SSL_MUX_TRI = 3'b000,
		SSL_MUX_HIGH = 3'b001,
		SSL_MUX_LOW = 3'b010,
		SSL_MUX_REF = 3'b011,
		SSL_MUX_FB = 3'b100,
		SSL_MUX_ALD = 3'b101,
		SSL_MUX_DLD = 3'b110,
		SSL_MUX_RSVD = 3'b111
	} ssl_mux_t;

	// ****************************************************************
	// software register port
	// ****************************************************************
	localparam int SSL_ADDR_W = 8;
	localparam logic [7:0] SSL_REG_STATUS = 8'h00;
	localparam logic [7:0] SSL_REG_MASK = 8'h04;
	localparam logic [7:0] SSL_REG_STATE = 8'h08;
	localparam logic [7:0] SSL_REG_LATCH0 = 8'h10;
	localparam logic [7:0] SSL_REG_LATCH5 = 8'h24;
	localparam int SSL_EV_W = 4;
	localparam int SSL_EV_COMMIT = 0;
	localparam int SSL_EV_BADSEL = 1;
	localparam int SSL_EV_LOST = 2;
	localparam int SSL_EV_GAIN = 3;
	localparam logic [3:0] SSL_MASK_RST = 4'h0;
	localparam logic [3:0] SSL_STATUS_RST = 4'h0;
	localparam int SSL_PIN_N = 9;

endpackage : ssl_pkg

// ===== design/ssl_sync.sv
// two flip-flop synchroniser for a group of outside levels
`timescale 1ns/1ps
module ssl_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// levels
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] stage1;

	always_ff @(posedge clk) begin
		if (reset) begin
			stage1 <= '0;
			sync_out <= '0;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end

endmodule : ssl_sync

// ===== design/ssl_edge.sv
// edge finder on a synchronised level
`timescale 1ns/1ps
module ssl_edge (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// level and edges
	input wire logic level,
	output logic rise,
	output logic fall
);
	logic level_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			level_q <= 1'b0;
		end else begin
			level_q <= level;
		end
	end

	assign rise = level & ~level_q;
	assign fall = ~level & level_q;

endmodule : ssl_edge

// ===== design/ssl_top.sv
// serial load port, latch bank and control pins of the synthesizer
`timescale 1ns/1ps
module ssl_top
	import ssl_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// serial load pins
	input wire logic serial_clock,
	input wire logic serial_data,
	input wire logic load_strobe,
	// control pins
	input wire logic chip_enable,
	input wire logic rf_output_power_down,
	// loop signals
	input wire logic analog_lock_detect,
	input wire logic digital_lock_detect,
	input wire logic ref_counter_out,
	input wire logic feedback_counter_out,
	// status pins
	output logic lock_indicator,
	output logic test_mux_output,
	output logic test_mux_output_oe_n,
	output logic pump_output_oe_n,
	output logic device_powered,
	// rf output control
	output logic rf_output_pins_enable,
	output logic [1:0] rf_output_level,
	output logic [2:0] rf_divider_select,
	// latch contents in use
	output logic [31:0] latch0_word,
	output logic [31:0] latch1_word,
	output logic [31:0] latch2_word,
	output logic [31:0] latch3_word,
	output logic [31:0] latch4_word,
	output logic [31:0] latch5_word,
	// software register port
	input wire logic [ssl_pkg::SSL_ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	output logic irq
);
	import ssl_pkg::*;

	// ****************************************************************
	// pin synchronisers and edges
	// ****************************************************************
	logic [SSL_PIN_N-1:0] pins_sync;
	logic sclk_s;
	logic sdata_s;
	logic strobe_s;
	logic ce_s;
	logic rfpd_s;
	logic ald_s;
	logic dld_s;
	logic ref_s;
	logic fb_s;
	logic sclk_rise;
	logic strobe_rise;
	logic lock_rise;
	logic lock_fall;

	ssl_sync #(.W(SSL_PIN_N)) u_sync (
		.clk(clk),
		.reset(reset),
		.async_in({serial_clock, serial_data, load_strobe, chip_enable,
			rf_output_power_down, analog_lock_detect, digital_lock_detect,
			ref_counter_out, feedback_counter_out}),
		.sync_out(pins_sync)
	);

	assign {sclk_s, sdata_s, strobe_s, ce_s, rfpd_s, ald_s, dld_s, ref_s, fb_s} = pins_sync;

	ssl_edge u_sclk_edge (
		.clk(clk),
		.reset(reset),
		.level(sclk_s),
		.rise(sclk_rise),
		.fall()
	);

	ssl_edge u_strobe_edge (
		.clk(clk),
		.reset(reset),
		.level(strobe_s),
		.rise(strobe_rise),
		.fall()
	);

	ssl_edge u_lock_edge (
		.clk(clk),
		.reset(reset),
		.level(dld_s),
		.rise(lock_rise),
		.fall(lock_fall)
	);

	// ****************************************************************
	// shift register
	// ****************************************************************
	logic [SSL_WORD_W-1:0] shift_word;

	always_ff @(posedge clk) begin
		if (reset) begin
			shift_word <= SSL_WORD_RST;
		end else if (sclk_rise) begin
			shift_word <= {shift_word[SSL_WORD_W-2:0], sdata_s};
		end
	end

	// ****************************************************************
	// latch bank
	// ****************************************************************
	logic [2:0] target_select_bits;
	logic sel_valid;
	logic commit;
	logic [SSL_WORD_W-1:0] latch_store [SSL_LATCH_N];
	logic [SSL_WORD_W-1:0] active1;
	logic [SSL_WORD_W-1:0] active3;
	logic [2:0] active_div;

	assign target_select_bits = shift_word[SSL_SEL_LSB +: SSL_SEL_W];
	assign sel_valid = (target_select_bits <= SSL_SEL_LAST);
	assign commit = strobe_rise & sel_valid;

	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < SSL_LATCH_N; i++) begin
				latch_store[i] <= SSL_WORD_RST;
			end
		end else if (commit) begin
			latch_store[target_select_bits] <= shift_word;
		end
	end

	// double-buffered words move into use on a latch zero commit
	always_ff @(posedge clk) begin
		if (reset) begin
			active1 <= SSL_WORD_RST;
			active3 <= SSL_WORD_RST;
			active_div <= 3'h0;
		end else if (commit && target_select_bits == SSL_SEL_ZERO) begin
			active1 <= latch_store[1];
			active3 <= latch_store[3];
			active_div <= latch_store[4][SSL_L4_DIV_LSB +: 3];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			latch0_word <= SSL_WORD_RST;
			latch1_word <= SSL_WORD_RST;
			latch2_word <= SSL_WORD_RST;
			latch3_word <= SSL_WORD_RST;
			latch4_word <= SSL_WORD_RST;
			latch5_word <= SSL_WORD_RST;
		end else begin
			latch0_word <= latch_store[0];
			latch1_word <= active1;
			latch2_word <= latch_store[2];
			latch3_word <= active3;
			latch4_word <= latch_store[4];
			latch5_word <= latch_store[5];
		end
	end

	// ****************************************************************
	// power, mute and rf output control
	// ****************************************************************
	logic soft_pd;
	logic powered;
	logic mute;
	logic [2:0] div_now;

	assign soft_pd = latch_store[2][SSL_L2_PD_BIT];
	assign powered = ce_s & ~soft_pd;
	assign mute = ~rfpd_s | ~latch_store[4][SSL_L4_RFEN_BIT]
		| (latch_store[4][SSL_L4_MTLD_BIT] & ~dld_s);
	assign div_now = latch_store[2][SSL_L2_DIVBUF_BIT] ? active_div
		: latch_store[4][SSL_L4_DIV_LSB +: 3];

	always_ff @(posedge clk) begin
		if (reset) begin
			device_powered <= 1'b0;
			pump_output_oe_n <= 1'b1;
		end else begin
			device_powered <= powered;
			pump_output_oe_n <= ~powered;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rf_output_pins_enable <= 1'b0;
			rf_output_level <= 2'h0;
			rf_divider_select <= 3'h0;
		end else begin
			rf_output_pins_enable <= powered & ~mute;
			rf_output_level <= latch_store[4][SSL_L4_LEVEL_LSB +: 2];
			rf_divider_select <= div_now;
		end
	end

	// ****************************************************************
	// lock indicator and test multiplexer
	// ****************************************************************
	ssl_mux_t mux_select_bits;
	logic next_mux;
	logic next_mux_oe_n;

	assign mux_select_bits = ssl_mux_t'(latch_store[2][SSL_L2_MUX_LSB +: 3]);

	always_comb begin
		next_mux = 1'b0;
		next_mux_oe_n = 1'b0;
		case (mux_select_bits)
			SSL_MUX_TRI: begin
				next_mux_oe_n = 1'b1;
			end
			SSL_MUX_HIGH: begin
				next_mux = 1'b1;
			end
			SSL_MUX_LOW: begin
				next_mux = 1'b0;
			end
			SSL_MUX_REF: begin
				next_mux = ref_s;
			end
			SSL_MUX_FB: begin
				next_mux = fb_s;
			end
			SSL_MUX_ALD: begin
				next_mux = ald_s;
			end
			SSL_MUX_DLD: begin
				next_mux = dld_s;
			end
			default: begin
				next_mux_oe_n = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			lock_indicator <= 1'b0;
			test_mux_output <= 1'b0;
			test_mux_output_oe_n <= 1'b1;
		end else begin
			lock_indicator <= dld_s;
			test_mux_output <= next_mux;
			test_mux_output_oe_n <= next_mux_oe_n;
		end
	end

	// ****************************************************************
	// event status, mask and interrupt
	// ****************************************************************
	logic [SSL_EV_W-1:0] status;
	logic [SSL_EV_W-1:0] mask;
	logic [SSL_EV_W-1:0] events;
	logic [SSL_EV_W-1:0] clear_bits;

	assign events = {lock_rise, lock_fall, strobe_rise & ~sel_valid, commit};
	assign clear_bits = (reg_write && reg_addr == SSL_REG_STATUS)
		? reg_wdata[SSL_EV_W-1:0] : '0;

	always_ff @(posedge clk) begin
		if (reset) begin
			status <= SSL_STATUS_RST;
		end else begin
			status <= (status & ~clear_bits) | events;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			mask <= SSL_MASK_RST;
		end else if (reg_write && reg_addr == SSL_REG_MASK) begin
			mask <= reg_wdata[SSL_EV_W-1:0];
		end
	end

	assign irq = |(status & mask);

	// ****************************************************************
	// register read port
	// ****************************************************************
	logic [31:0] next_rdata;
	logic [2:0] latch_idx;

	assign latch_idx = 3'(reg_addr[4:2] - 3'h4);

	always_comb begin
		next_rdata = 32'h0000_0000;
		if (reg_addr == SSL_REG_STATUS) begin
			next_rdata[SSL_EV_W-1:0] = status;
		end else if (reg_addr == SSL_REG_MASK) begin
			next_rdata[SSL_EV_W-1:0] = mask;
		end else if (reg_addr == SSL_REG_STATE) begin
			next_rdata[7:0] = {target_select_bits, mute, powered, rfpd_s, ce_s, dld_s};
		end else if (reg_addr >= SSL_REG_LATCH0 && reg_addr <= SSL_REG_LATCH5
			&& reg_addr[1:0] == 2'h0) begin
			next_rdata = latch_store[latch_idx];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_read) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

endmodule : ssl_top

// ===== bench/ssl_host_model.sv
// host controller model driving the serial load pins
`timescale 1ns/1ps
module ssl_host_model (
	// serial load pins
	output logic serial_clock,
	output logic serial_data,
	output logic load_strobe
);
	initial begin
		serial_clock = 1'b0;
		serial_data = 1'b0;
		load_strobe = 1'b0;
	end
	// ****
	// one word, clock still outside the frame
	// ****
	task automatic send(input logic [31:0] w);
		#7;
		for (int i = 31; i >= 0; i--) begin
			serial_data = w[i];
			#80 serial_clock = 1'b1;
			#80 serial_clock = 1'b0;
		end
		serial_data = ~w[0];
		#80 load_strobe = 1'b1;
		#160 load_strobe = 1'b0;
		#80;
	endtask : send
endmodule : ssl_host_model

// ===== bench/ssl_top_sva.sv
// port assertions of the serial load block
`timescale 1ns/1ps
module ssl_top_sva (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// watched ports
	input wire logic load_strobe,
	input wire logic chip_enable,
	input wire logic rf_output_power_down,
	input wire logic digital_lock_detect,
	input wire logic lock_indicator,
	input wire logic test_mux_output,
	input wire logic test_mux_output_oe_n,
	input wire logic pump_output_oe_n,
	input wire logic device_powered,
	input wire logic rf_output_pins_enable,
	input wire logic [1:0] rf_output_level,
	input wire logic [31:0] latch0_word,
	input wire logic [31:0] latch2_word,
	input wire logic [31:0] latch4_word
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// ****
	// sequences
	// ****
	sequence s_ce_low;
		!chip_enable [*4];
	endsequence
	sequence s_quiet;
		!load_strobe [*8];
	endsequence
	// ****
	// assertions
	// ****
	a_pump_float: assert property (s_ce_low |-> pump_output_oe_n && !device_powered)
		else $error("pump not floated");
	a_power_up: assert property ((chip_enable && !latch2_word[5]) [*4] |-> device_powered)
		else $error("not powered");
	a_soft_pd: assert property (latch2_word[5] [*3] |-> !device_powered && pump_output_oe_n)
		else $error("soft power-down ignored");
	a_pin_mute: assert property (!rf_output_power_down [*4] |-> !rf_output_pins_enable)
		else $error("pin mute ignored");
	a_soft_mute: assert property (!latch4_word[5] [*3] |-> !rf_output_pins_enable)
		else $error("soft mute ignored");
	a_lock_high: assert property (digital_lock_detect [*4] |-> lock_indicator)
		else $error("lock not shown");
	a_lock_low: assert property (!digital_lock_detect [*4] |-> !lock_indicator)
		else $error("lock loss not shown");
	a_mux_tri: assert property ((latch2_word[28:26] == 3'h0) [*2] |-> test_mux_output_oe_n)
		else $error("mux not floated");
	a_mux_high: assert property ((latch2_word[28:26] == 3'h1) [*2] |->
		test_mux_output && !test_mux_output_oe_n)
		else $error("mux not high");
	a_level_field: assert property ($stable(latch4_word) [*3] |->
		rf_output_level == latch4_word[4:3])
		else $error("level mismatch");
	a_latch_hold: assert property (s_quiet |-> $stable(latch0_word) && $stable(latch2_word))
		else $error("latch changed without strobe");
endmodule : ssl_top_sva

// ===== bench/ssl_top_tb.sv
// self-checking bench of the serial load block
`timescale 1ns/1ps
module ssl_top_tb;
	import ssl_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic chip_enable = 1'b0, rf_output_power_down = 1'b0;
	logic analog_lock_detect = 1'b0, digital_lock_detect = 1'b0;
	logic ref_counter_out = 1'b0, feedback_counter_out = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, rdv;
	logic reg_write = 1'b0, reg_read = 1'b0;
	wire logic serial_clock, serial_data, load_strobe, lock_indicator, irq;
	wire logic test_mux_output, test_mux_output_oe_n, pump_output_oe_n;
	wire logic device_powered, rf_output_pins_enable;
	wire logic [1:0] rf_output_level;
	wire logic [2:0] rf_divider_select;
	wire logic [31:0] reg_rdata;
	wire logic [31:0] lw [6];
	logic [31:0] exp_l [6] = '{default: 32'h0};
	logic [31:0] pend [6] = '{default: 32'h0};
	int failures = 0, tests_run = 0;
	initial forever #10 clk = ~clk;
	ssl_host_model host_i (
		.serial_clock(serial_clock),
		.serial_data(serial_data),
		.load_strobe(load_strobe)
	);
	ssl_top ssl_top_i (
		.clk(clk), .reset(reset),
		.serial_clock(serial_clock), .serial_data(serial_data), .load_strobe(load_strobe),
		.chip_enable(chip_enable), .rf_output_power_down(rf_output_power_down),
		.analog_lock_detect(analog_lock_detect), .digital_lock_detect(digital_lock_detect),
		.ref_counter_out(ref_counter_out), .feedback_counter_out(feedback_counter_out),
		.lock_indicator(lock_indicator), .test_mux_output(test_mux_output),
		.test_mux_output_oe_n(test_mux_output_oe_n), .pump_output_oe_n(pump_output_oe_n),
		.device_powered(device_powered), .rf_output_pins_enable(rf_output_pins_enable),
		.rf_output_level(rf_output_level), .rf_divider_select(rf_divider_select),
		.latch0_word(lw[0]), .latch1_word(lw[1]), .latch2_word(lw[2]),
		.latch3_word(lw[3]), .latch4_word(lw[4]), .latch5_word(lw[5]),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq)
	);
	// ****
	// helpers
	// ****
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			failures++;
			$display("FAIL %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
		@(negedge clk);
	endtask : wreg
	task automatic rreg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask : rreg
	function automatic void exp_upd(input logic [31:0] w);
		case (w[2:0])
			3'h1, 3'h3: pend[w[2:0]] = w;
			3'h6, 3'h7: ;
			default: exp_l[w[2:0]] = w;
		endcase
		if (w[2:0] == 3'h0) begin
			exp_l[1] = pend[1];
			exp_l[3] = pend[3];
		end
	endfunction : exp_upd
	function automatic logic mux_exp(input int m);
		case (m)
			1: return 1'b1;
			3: return ref_counter_out;
			4: return feedback_counter_out;
			5: return analog_lock_detect;
			6: return digital_lock_detect;
			default: return 1'b0;
		endcase
	endfunction : mux_exp
	task automatic put(input logic [31:0] w);
		host_i.send(w);
		exp_upd(w);
		for (int i = 0; i < 6; i++)
			chk("latch", exp_l[i], lw[i]);
	endtask : put
	// ****
	// tests
	// ****
	initial begin
		void'($urandom(96532));
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		repeat (5) @(posedge clk);
		chk("pump_oe_n", 1, pump_output_oe_n);
		rreg(SSL_REG_STATUS, rdv);
		chk("status", 0, rdv);
		wreg(8'hFC, $urandom());
		rreg(8'hFC, rdv);
		chk("unmapped", 0, rdv);
		repeat (2)
			for (int s = 0; s < 8; s++)
				put(($urandom() & 32'hFFFF_FFF8) | s);
		rreg(SSL_REG_STATUS, rdv);
		chk("status", 32'h3, rdv);
		wreg(SSL_REG_MASK, 32'h2);
		chk("irq", 1, irq);
		wreg(SSL_REG_STATUS, 32'h2);
		chk("irq", 0, irq);
		wreg(SSL_REG_MASK, 32'h1);
		chk("irq", 1, irq);
		wreg(SSL_REG_MASK, 32'h0);
		chk("irq", 0, irq);
		@(posedge clk);
		chip_enable <= 1'b1;
		rf_output_power_down <= 1'b1;
		for (int m = 0; m < 8; m++) begin
			put((m << 26) | 2);
			@(posedge clk);
			{ref_counter_out, feedback_counter_out, analog_lock_detect,
				digital_lock_detect} <= 4'($urandom());
			repeat (6) @(posedge clk);
			@(negedge clk);
			chk("mux_oe_n", m == 0 || m == 7, test_mux_output_oe_n);
			if (m > 0 && m < 7)
				chk("mux", mux_exp(m), test_mux_output);
			chk("lock", digital_lock_detect, lock_indicator);
		end
		put(32'h0000_0024 | ($urandom() & 32'h18));
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			chip_enable <= k[0];
			rf_output_power_down <= k[1];
			repeat (6) @(posedge clk);
			@(negedge clk);
			chk("powered", k[0], device_powered);
			chk("pump_oe_n", !k[0], pump_output_oe_n);
			chk("rf_en", k == 3, rf_output_pins_enable);
		end
		chk("level", exp_l[4][4:3], rf_output_level);
		rreg(SSL_REG_STATE, rdv);
		chk("state", 32'h8E | digital_lock_detect, rdv);
		put(32'h0000_0022);
		chk("powered", 0, device_powered);
		put(32'h0000_0002);
		put(32'h0000_0004);
		chk("rf_en", 0, rf_output_pins_enable);
		put(32'h0050_0004);
		chk("div", 3'h5, rf_divider_select);
		put(32'h0000_0000);
		put(32'h0000_2002);
		put(32'h0020_0004);
		chk("div", 3'h5, rf_divider_select);
		put(32'h0000_0000);
		chk("div", 3'h2, rf_divider_select);
		for (int i = 0; i < 6; i++) begin
			rreg(8'(SSL_REG_LATCH0 + 4 * i), rdv);
			chk("readback", (i == 1 || i == 3) ? pend[i] : exp_l[i], rdv);
		end
		end_sim();
	end
	initial begin
		#1000000;
		failures++;
		end_sim();
	end
	task automatic end_sim();
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim
endmodule : ssl_top_tb
bind ssl_top ssl_top_sva ssl_top_sva_i (
	.clk(clk), .reset(reset), .load_strobe(load_strobe), .chip_enable(chip_enable),
	.rf_output_power_down(rf_output_power_down), .digital_lock_detect(digital_lock_detect),
	.lock_indicator(lock_indicator), .test_mux_output(test_mux_output),
	.test_mux_output_oe_n(test_mux_output_oe_n), .pump_output_oe_n(pump_output_oe_n),
	.device_powered(device_powered), .rf_output_pins_enable(rf_output_pins_enable),
	.rf_output_level(rf_output_level), .latch0_word(latch0_word),
	.latch2_word(latch2_word), .latch4_word(latch4_word)
);
